// *** common/hdlc_link_pkg.sv ***
package hdlc_link_pkg;
    // Register map
    localparam logic [15:0] TX_LINK_BUFFER_AND_COUNT_ADDR = 16'h0120;
    localparam logic [15:0] RX_LINK_BUFFER_AND_COUNT_ADDR = 16'h0121;
    localparam logic [7:0] TX_BUF0_PAGE = 8'h06;
    localparam logic [7:0] TX_BUF1_PAGE = 8'h07;
    localparam logic [7:0] RX_BUF0_PAGE = 8'h08;
    localparam logic [7:0] RX_BUF1_PAGE = 8'h09;
    // Field layout of both buffer-and-count registers
    localparam int SELECT_BIT = 7;
    localparam int COUNT_MSB = 6;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [6:0] COUNT_ZERO = 7'h00;
    // Buffer geometry
    localparam int BUF_BYTES = 96;
    localparam int BIT_MSG_BYTES = 2;
    localparam int TX_FIFO_DEPTH = 32;

    // Microprocessor register request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // Byte arriving from the receive deframer
    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic last;
        logic bitRepeat;
    } rx_link_t;

    typedef enum logic [0:0] {
        TX_IDLE,
        TX_SEND
    } tx_state_t;
endpackage

// *** rtl/hdlc_link_buffer_count_ctrl.sv ***
`timescale 1ns/1ps
module link_byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    // Fill side
    input wire logic inValid,
    input wire logic [WIDTH-1:0] inData,
    output logic inReady,
    // Drain side, registered
    output logic outValid,
    output logic [WIDTH-1:0] outData,
    input wire logic outReady
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_q;
    logic [AW-1:0] rdPtr_q;
    logic [AW:0] cnt_q;
    logic outValid_q;
    logic [WIDTH-1:0] outData_q;
    wire push;
    wire load;
    wire [AW:0] cnt_d;

    // Full only when the memory holds DEPTH words; output stage is extra
    assign inReady = (cnt_q != DEPTH[AW:0]);
    assign push = ce && inValid && inReady;
    assign load = ce && (cnt_q != '0) && (!outValid_q || outReady);
    assign cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
    assign outValid = outValid_q;
    assign outData = outData_q;

    // Storage has no reset; only pointers, count and output register need one
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr_q] <= inData;
        end
    end

    // Pointers and output register
    always_ff @(posedge clk) begin
        if (!resetn) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            cnt_q <= '0;
            outValid_q <= 1'b0;
            outData_q <= '0;
        end else if (ce) begin
            wrPtr_q <= push ? wrPtr_q + 1'b1 : wrPtr_q;
            rdPtr_q <= load ? rdPtr_q + 1'b1 : rdPtr_q;
            cnt_q <= cnt_d;
            if (load) begin
                outValid_q <= 1'b1;
                outData_q <= mem[rdPtr_q];
            end else if (outReady) begin
                outValid_q <= 1'b0;
            end
        end
    end
endmodule

module hdlc_link_buffer_count_ctrl #(
    parameter int BUF_BYTES = hdlc_link_pkg::BUF_BYTES,
    parameter int BIT_MSG_BYTES = hdlc_link_pkg::BIT_MSG_BYTES,
    parameter int FIFO_DEPTH = hdlc_link_pkg::TX_FIFO_DEPTH
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    // Register port
    input wire hdlc_link_pkg::reg_req_t regReq,
    output logic [7:0] regRdData,
    output logic regRdValid,
    // Message type selects
    input wire logic txMessageType,
    input wire logic rxMessageOriented,
    // Transmit link byte stream
    output logic [7:0] txLinkData,
    output logic txLinkValid,
    input wire logic txLinkReady,
    // Receive link byte stream
    input wire hdlc_link_pkg::rx_link_t rxLink,
    // End-of-transfer events
    output logic txEndOfTransferIrq,
    output logic rxEndOfTransferIrq
);
    logic [7:0] txMem [2][BUF_BYTES];
    logic [7:0] rxMem [2][BUF_BYTES];
    hdlc_link_pkg::tx_state_t txState_q;
    logic txActiveBuf_q;
    logic txBufferSelect_q;
    logic [6:0] txMessageCount_q;
    logic txMsgMode_q;
    logic [6:0] txIdx_q;
    logic [6:0] txRep_q;
    logic tx_end_of_transfer_irq_q;
    logic rxLatestBufferPointer_q;
    logic [6:0] rxMessageCount_q;
    logic [6:0] rxIdx_q;
    logic [6:0] rxRep_q;
    logic rx_end_of_transfer_irq_q;
    logic [7:0] rdData_q;
    logic rdValid_q;
    logic fifoInReady;

    // Address decode
    wire [7:0] page = regReq.addr[15:8];
    wire [7:0] byteIdx = regReq.addr[7:0];
    wire inBuf = byteIdx < BUF_BYTES[7:0];
    wire [6:0] bufIdx = byteIdx[6:0];
    wire txRegWr = ce && regReq.wr && regReq.addr == hdlc_link_pkg::TX_LINK_BUFFER_AND_COUNT_ADDR;
    wire rxRegWr = ce && regReq.wr && regReq.addr == hdlc_link_pkg::RX_LINK_BUFFER_AND_COUNT_ADDR;
    wire txBufHit = inBuf && (page == hdlc_link_pkg::TX_BUF0_PAGE
                           || page == hdlc_link_pkg::TX_BUF1_PAGE);
    wire rxBufHit = inBuf && (page == hdlc_link_pkg::RX_BUF0_PAGE
                           || page == hdlc_link_pkg::RX_BUF1_PAGE);
    wire txBufWr = ce && regReq.wr && txBufHit;
    wire txBufSel = (page == hdlc_link_pkg::TX_BUF1_PAGE);
    wire rxBufSel = (page == hdlc_link_pkg::RX_BUF1_PAGE);

    // Read-back of the two count registers
    wire [7:0] txRegRead = {txBufferSelect_q, txMessageCount_q};
    wire [7:0] rxRegRead = {rxLatestBufferPointer_q, rxMessageCount_q};
    wire [7:0] rdMux =
        (regReq.addr == hdlc_link_pkg::TX_LINK_BUFFER_AND_COUNT_ADDR) ? txRegRead :
        (regReq.addr == hdlc_link_pkg::RX_LINK_BUFFER_AND_COUNT_ADDR) ? rxRegRead :
        txBufHit ? txMem[txBufSel][bufIdx] :
        rxBufHit ? rxMem[rxBufSel][bufIdx] : 8'h00;

    // Transmit engine datapath
    wire txBusy = (txState_q == hdlc_link_pkg::TX_SEND);
    wire txPush = txBusy && fifoInReady;
    wire [7:0] txByte = (txIdx_q < BUF_BYTES[6:0]) ? txMem[txActiveBuf_q][txIdx_q] : 8'h00;
    wire txLastByte = txMsgMode_q ? (txIdx_q == txMessageCount_q - 7'h01)
                                  : (txIdx_q == BIT_MSG_BYTES[6:0] - 7'h01);
    wire txLastRep = (txMessageCount_q != hdlc_link_pkg::COUNT_ZERO)
                  && (txRep_q == txMessageCount_q - 7'h01);
    wire txDone = txPush && txLastByte && (txMsgMode_q || txLastRep);
    wire txEmptyMsg = txMessageType && (regReq.wdata[6:0] == hdlc_link_pkg::COUNT_ZERO);

    // Receive datapath
    wire rxTake = ce && rxLink.valid && rxMessageOriented;
    wire rxWrBuf = ~rxLatestBufferPointer_q;
    wire rxCommit = rxTake && rxLink.last;
    wire [6:0] rxSize = (rxIdx_q < BUF_BYTES[6:0]) ? rxIdx_q + 7'h01 : rxIdx_q;
    wire rxRepHit = ce && rxLink.bitRepeat && !rxMessageOriented
                 && (rxMessageCount_q != hdlc_link_pkg::COUNT_ZERO);
    wire rxRepDone = rxRepHit && (rxRep_q == rxMessageCount_q - 7'h01);

    // Software fills transmit buffers; no reset on storage
    always_ff @(posedge clk) begin
        if (txBufWr) begin
            txMem[txBufSel][bufIdx] <= regReq.wdata;
        end
    end

    // Received message octets land in the buffer not pointed at
    always_ff @(posedge clk) begin
        if (rxTake && rxIdx_q < BUF_BYTES[6:0]) begin
            rxMem[rxWrBuf][rxIdx_q] <= rxLink.data;
        end
    end

    // Register read answer, one cycle after the strobe
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rdData_q <= 8'h00;
            rdValid_q <= 1'b0;
        end else if (ce) begin
            rdValid_q <= regReq.rd;
            rdData_q <= regReq.rd ? rdMux : rdData_q;
        end
    end

    // Transmit control; a new write abandons any message in flight
    always_ff @(posedge clk) begin
        if (!resetn) begin
            txState_q <= hdlc_link_pkg::TX_IDLE;
            txActiveBuf_q <= 1'b0;
            txBufferSelect_q <= 1'b0;
            txMessageCount_q <= hdlc_link_pkg::COUNT_ZERO;
            txMsgMode_q <= 1'b0;
            txIdx_q <= 7'h00;
            txRep_q <= 7'h00;
            tx_end_of_transfer_irq_q <= 1'b0;
        end else if (ce) begin
            tx_end_of_transfer_irq_q <= txDone && !txRegWr;
            if (txRegWr) begin
                txActiveBuf_q <= regReq.wdata[hdlc_link_pkg::SELECT_BIT];
                txBufferSelect_q <= ~regReq.wdata[hdlc_link_pkg::SELECT_BIT];
                txMessageCount_q <= regReq.wdata[hdlc_link_pkg::COUNT_MSB:0];
                txMsgMode_q <= txMessageType;
                txIdx_q <= 7'h00;
                txRep_q <= 7'h00;
                // Zero-length message-oriented send has nothing to take in
                txState_q <= txEmptyMsg ? hdlc_link_pkg::TX_IDLE : hdlc_link_pkg::TX_SEND;
            end else if (txDone) begin
                txState_q <= hdlc_link_pkg::TX_IDLE;
                txIdx_q <= 7'h00;
            end else if (txPush && txLastByte) begin
                txIdx_q <= 7'h00;
                txRep_q <= txRep_q + 7'h01;
            end else if (txPush) begin
                txIdx_q <= txIdx_q + 7'h01;
            end
        end
    end

    // Receive pointer and count; hardware update wins over a software write
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rxLatestBufferPointer_q <= 1'b0;
            rxMessageCount_q <= hdlc_link_pkg::COUNT_ZERO;
            rxIdx_q <= 7'h00;
            rxRep_q <= 7'h00;
            rx_end_of_transfer_irq_q <= 1'b0;
        end else if (ce) begin
            rx_end_of_transfer_irq_q <= rxRepDone;
            if (rxCommit) begin
                rxLatestBufferPointer_q <= rxWrBuf;
                rxMessageCount_q <= rxSize;
            end else if (rxRegWr) begin
                rxLatestBufferPointer_q <= regReq.wdata[hdlc_link_pkg::SELECT_BIT];
                rxMessageCount_q <= regReq.wdata[hdlc_link_pkg::COUNT_MSB:0];
            end
            if (rxCommit) begin
                rxIdx_q <= 7'h00;
            end else if (rxTake && rxIdx_q < BUF_BYTES[6:0]) begin
                rxIdx_q <= rxIdx_q + 7'h01;
            end
            if (rxRepDone || rxRegWr) begin
                rxRep_q <= 7'h00;
            end else if (rxRepHit) begin
                rxRep_q <= rxRep_q + 7'h01;
            end
        end
    end

    // Outbound bytes queue here so a slow link stalls the engine
    link_byte_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) txFifo (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .inValid(txBusy),
        .inData(txByte),
        .inReady(fifoInReady),
        .outValid(txLinkValid),
        .outData(txLinkData),
        .outReady(txLinkReady)
    );

    // Registered outputs
    assign regRdData = rdData_q;
    assign regRdValid = rdValid_q;
    assign txEndOfTransferIrq = tx_end_of_transfer_irq_q;
    assign rxEndOfTransferIrq = rx_end_of_transfer_irq_q;

    property p_tx_select;
        @(posedge clk) disable iff (!resetn)
        txRegWr && !txEmptyMsg |=> txBusy && txActiveBuf_q == $past(regReq.wdata[7]);
    endproperty
    a_tx_select: assert property (p_tx_select) else $error("tx buffer not selected");

    property p_tx_avail;
        @(posedge clk) disable iff (!resetn)
        txBusy |-> txRegRead[7] == ~txActiveBuf_q;
    endproperty
    a_tx_avail: assert property (p_tx_avail) else $error("busy buffer reported free");

    property p_avail_read;
        @(posedge clk) disable iff (!resetn)
        ce && regReq.rd && regReq.addr == hdlc_link_pkg::TX_LINK_BUFFER_AND_COUNT_ADDR
        |=> regRdValid && regRdData[7] == $past(txBufferSelect_q);
    endproperty
    a_avail_read: assert property (p_avail_read) else $error("bad select read-back");

    property p_tx_eot;
        @(posedge clk) disable iff (!resetn)
        txEndOfTransferIrq && $past(ce) |-> !txBusy && $past(txPush) && $past(txLastByte);
    endproperty
    a_tx_eot: assert property (p_tx_eot) else $error("tx end-of-transfer misplaced");

    property p_tx_endless;
        @(posedge clk) disable iff (!resetn)
        txBusy && !txMsgMode_q && txMessageCount_q == 7'h00 && !txRegWr
        |=> txBusy && !txEndOfTransferIrq;
    endproperty
    a_tx_endless: assert property (p_tx_endless) else $error("endless repeat stopped");

    property p_tx_msg_len;
        @(posedge clk) disable iff (!resetn)
        ce && txPush && txMsgMode_q && !txRegWr && txIdx_q == txMessageCount_q - 7'h01 |=> !txBusy;
    endproperty
    a_tx_msg_len: assert property (p_tx_msg_len) else $error("message length not kept");

    property p_rx_commit;
        @(posedge clk) disable iff (!resetn)
        rxCommit |=> rxLatestBufferPointer_q == !$past(rxLatestBufferPointer_q)
                     && rxMessageCount_q == $past(rxSize);
    endproperty
    a_rx_commit: assert property (p_rx_commit) else $error("rx pointer and count split");

    property p_rx_size;
        @(posedge clk) disable iff (!resetn)
        rxCommit && rxIdx_q < BUF_BYTES[6:0] |=> rxMessageCount_q == $past(rxIdx_q) + 7'h01;
    endproperty
    a_rx_size: assert property (p_rx_size) else $error("rx size not loaded");

    property p_rx_eot;
        @(posedge clk) disable iff (!resetn)
        rxRepHit && rxRep_q == rxMessageCount_q - 7'h01 |=> rxEndOfTransferIrq;
    endproperty
    a_rx_eot: assert property (p_rx_eot) else $error("rx end-of-transfer missing");

    property p_rx_endless;
        @(posedge clk) disable iff (!resetn)
        ce && rxMessageCount_q == 7'h00 |=> !rxEndOfTransferIrq;
    endproperty
    a_rx_endless: assert property (p_rx_endless) else $error("rx event with zero count");

    property p_tx_type;
        @(posedge clk) disable iff (!resetn)
        txRegWr |=> txMsgMode_q == $past(txMessageType);
    endproperty
    a_tx_type: assert property (p_tx_type) else $error("message type not sampled");
endmodule

// *** tb/hdlc_link_buffer_count_ctrl_bench.sv ***
`timescale 1ns/1ps
module hdlc_link_buffer_count_ctrl_bench;
    localparam logic [15:0] txAddr = hdlc_link_pkg::TX_LINK_BUFFER_AND_COUNT_ADDR;
    localparam logic [15:0] rxAddr = hdlc_link_pkg::RX_LINK_BUFFER_AND_COUNT_ADDR;
    typedef struct packed {
        logic msgMode;
        logic bufSel;
        logic [6:0] count;
        logic [7:0] nBytes;
        logic irq;
    } tx_row_t;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b1;
    logic hold = 1'b0;
    logic txMessageType = 1'b0;
    logic rxMessageOriented = 1'b1;
    hdlc_link_pkg::reg_req_t regReq = '0;
    hdlc_link_pkg::rx_link_t rxLink;
    logic [7:0] regRdData, txLinkData, rd;
    logic regRdValid, txLinkValid, txLinkReady, txEndOfTransferIrq, rxEndOfTransferIrq;
    int err_count = 0;
    int compares = 0;
    int txIrqs = 0;
    int rxIrqs = 0;
    int n;
    // Ordinary sends: mode, buffer, count, bytes expected, end event expected
    tx_row_t rows[5] = '{
        '{1'b1, 1'b0, 7'h03, 8'h03, 1'b1},
        '{1'b1, 1'b1, 7'h01, 8'h01, 1'b1},
        '{1'b0, 1'b0, 7'h02, 8'h04, 1'b1},
        '{1'b1, 1'b1, 7'h00, 8'h00, 1'b0},
        '{1'b0, 1'b1, 7'h01, 8'h02, 1'b1}
    };

    hdlc_link_buffer_count_ctrl hdlc_link_buffer_count_ctrl_inst (
        .clk(clk), .resetn(resetn), .ce(ce), .regReq(regReq), .regRdData(regRdData),
        .regRdValid(regRdValid), .txMessageType(txMessageType),
        .rxMessageOriented(rxMessageOriented), .txLinkData(txLinkData),
        .txLinkValid(txLinkValid), .txLinkReady(txLinkReady), .rxLink(rxLink),
        .txEndOfTransferIrq(txEndOfTransferIrq), .rxEndOfTransferIrq(rxEndOfTransferIrq)
    );
    remote_terminal_model remote_terminal_model_inst (
        .clk(clk), .txLinkData(txLinkData), .txLinkValid(txLinkValid),
        .txLinkReady(txLinkReady), .rxLink(rxLink), .hold(hold)
    );

    always #5 clk = ~clk;

    // Count one-cycle end events as they pass
    always @(posedge clk) begin
        if (txEndOfTransferIrq === 1'b1) txIrqs++;
        if (rxEndOfTransferIrq === 1'b1) rxIrqs++;
    end

    task automatic check(input logic [7:0] act, input logic [7:0] exp);
        compares++;
        if (act !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, act, exp);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask

    task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        regReq = '{1'b1, 1'b0, a, d};
        @(negedge clk);
        regReq = '0;
    endtask

    // Read answer is registered one cycle after the strobe is taken
    task automatic reg_rd(input logic [15:0] a, output logic [7:0] d);
        @(negedge clk);
        regReq = '{1'b0, 1'b1, a, 8'h00};
        @(negedge clk);
        regReq = '0;
        d = regRdValid === 1'b1 ? regRdData : 8'hXX;
    endtask

    // Done once the outbound stream has been quiet for five cycles
    task automatic drain();
        n = 0;
        for (int t = 0; t < 500 && n < 5; t++) begin
            @(negedge clk);
            n = txLinkValid === 1'b1 ? 0 : n + 1;
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #300000;
        err_count++;
        final_report();
    end

    initial begin
        cyc(12);
        resetn = 1'b1;
        reg_rd(txAddr, rd);
        check(rd, 8'h00);
        reg_rd(rxAddr, rd);
        check(rd, 8'h00);
        reg_rd(16'h0122, rd);
        check(rd, 8'h00);
        for (int i = 0; i < 4; i++) begin
            reg_wr({hdlc_link_pkg::TX_BUF0_PAGE, 8'(i)}, 8'h10 + 8'(i));
            reg_wr({hdlc_link_pkg::TX_BUF1_PAGE, 8'(i)}, 8'h50 + 8'(i));
        end
        reg_rd({hdlc_link_pkg::TX_BUF1_PAGE, 8'h02}, rd);
        check(rd, 8'h52);
        // Table of ordinary sends; readback taken just after each write
        foreach (rows[r]) begin
            remote_terminal_model_inst.got.delete();
            txIrqs = 0;
            txMessageType = rows[r].msgMode;
            reg_wr(txAddr, {rows[r].bufSel, rows[r].count});
            reg_rd(txAddr, rd);
            check(rd, {~rows[r].bufSel, rows[r].count});
            drain();
            check(8'(remote_terminal_model_inst.got.size()), rows[r].nBytes);
            foreach (remote_terminal_model_inst.got[k]) begin
                check(remote_terminal_model_inst.got[k], (rows[r].bufSel ? 8'h50 : 8'h10)
                    + 8'(rows[r].msgMode ? k : k % 2));
            end
            check(8'(txIrqs), {7'h00, rows[r].irq});
        end
        // Endless repeat against a stalled sink: FIFO fills, output stands
        remote_terminal_model_inst.got.delete();
        txIrqs = 0;
        hold = 1'b1;
        txMessageType = 1'b0;
        reg_wr(txAddr, 8'h00);
        cyc(60);
        rd = txLinkData;
        cyc(5);
        check(txLinkData, rd);
        check(8'(txLinkValid), 8'h01);
        check(8'(remote_terminal_model_inst.got.size()), 8'h00);
        hold = 1'b0;
        cyc(100);
        check(8'(remote_terminal_model_inst.got.size() > 40), 8'h01);
        check(8'(txIrqs), 8'h00);
        // A new send abandons the endless one
        txMessageType = 1'b1;
        reg_wr(txAddr, 8'h81);
        drain();
        check(8'(txIrqs), 8'h01);
        check(remote_terminal_model_inst.got[$], 8'h50);
        // Two received messages alternate buffers
        remote_terminal_model_inst.send_msg(3, 8'hC0);
        reg_rd(rxAddr, rd);
        check(rd, 8'h83);
        reg_rd({hdlc_link_pkg::RX_BUF1_PAGE, 8'h02}, rd);
        check(rd, 8'hC2);
        remote_terminal_model_inst.send_msg(2, 8'hD0);
        reg_rd(rxAddr, rd);
        check(rd, 8'h02);
        reg_rd({hdlc_link_pkg::RX_BUF0_PAGE, 8'h01}, rd);
        check(rd, 8'hD1);
        // Bit-oriented receive: count of three, then count zero
        rxMessageOriented = 1'b0;
        for (int c = 0; c < 2; c++) begin
            reg_wr(rxAddr, c ? 8'h00 : 8'h03);
            rxIrqs = 0;
            repeat (c ? 5 : 3) remote_terminal_model_inst.send_repeat();
            cyc(3);
            check(8'(rxIrqs), c ? 8'h00 : 8'h01);
        end
        // Enable low freezes the block, so this write is lost
        ce = 1'b0;
        reg_wr(txAddr, 8'h85);
        ce = 1'b1;
        reg_rd(txAddr, rd);
        check(rd, 8'h01);
        final_report();
    end
endmodule

// *** tb/remote_terminal_model.sv ***
`timescale 1ns/1ps
module remote_terminal_model (
    // Clock
    input wire logic clk,
    // Outbound stream from the block
    input wire logic [7:0] txLinkData,
    input wire logic txLinkValid,
    output logic txLinkReady,
    // Inbound stream to the block
    output hdlc_link_pkg::rx_link_t rxLink,
    // Bench control: stall the sink outright
    input wire logic hold
);
    logic [7:0] got[$];
    int phase = 0;

    // Ready drops every third cycle so the FIFO output must stand
    always @(negedge clk) begin
        phase <= (phase + 1) % 3;
    end
    assign txLinkReady = !hold && phase != 0;

    // Byte is taken only where valid and ready meet
    always @(posedge clk) begin
        if (txLinkValid === 1'b1 && txLinkReady) begin
            got.push_back(txLinkData);
        end
    end

    initial rxLink = '0;

    // Idle data is inverted so a stale byte never looks current
    task automatic send_msg(input int len, input logic [7:0] base);
        for (int i = 0; i < len; i++) begin
            @(negedge clk);
            rxLink = '{1'b1, base + 8'(i), i == len - 1, 1'b0};
        end
        @(negedge clk);
        rxLink = '{1'b0, ~rxLink.data, 1'b0, 1'b0};
    endtask

    // One received bit-oriented repetition
    task automatic send_repeat();
        @(negedge clk);
        rxLink = '{1'b0, ~rxLink.data, 1'b0, 1'b1};
        @(negedge clk);
        rxLink = '{1'b0, ~rxLink.data, 1'b0, 1'b0};
    endtask
endmodule
